//--- design/cssi_pkg.sv
// Purpose: Constants for the config and status serial interface
// Assumes: 250 MHz core clock, byte-wide register map
// Notes: Offsets are register-address bytes on the serial port
// Contract
// - Serial port is slave only, 100k/400k
// - Pulses under 50 ns on bus ignored
// - Answer only address 10101 plus strap bits
// - Three-level strap sets low address bits
// - Data changes only while clock low
// - Bytes eight bits, MSB first, then ack
// - Writes to read-only bits ignored
// - Power-up load from ROM or EEPROM
// - EEPROM rewrite limited, ROM never rewritten
// - Differential loss by swing thresholds
// - Single-ended loss by amplitude or slew
// - Loss sets flag and drives status
// - Slip count over limit flags lock loss
// - Status codes 0 to 7 mapping
// - Status codes 8 to 15 mapping
// - Status pins as divided clock outputs
// - Status clock muted on lock loss
// - Register selects slow status edges
// - Register address then auto-increment
package cssi_pkg;
  localparam int         GLITCH_NS        = 50;
  localparam int         CLK_MHZ          = 250;
  localparam int         GLITCH_CYC       = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int         BOOT_CYC         = 3;
  localparam int         REG_AW           = 6;
  localparam int         REG_DEPTH        = 64;
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam logic [4:0] ADDR_HI          = 5'h15;
  localparam logic [7:0] REG_FLAGS        = 8'h0d;
  localparam logic [7:0] REG_STAT_POL     = 8'h0f;
  localparam logic [7:0] REG_STAT_MUTE    = 8'h17;
  localparam logic [7:0] REG_LOSCFG       = 8'h19;
  localparam logic [7:0] REG_STAT_SEL0    = 8'h1b;
  localparam logic [7:0] REG_STAT_SEL1    = 8'h1c;
  localparam logic [7:0] REG_SLEW         = 8'h31;
  localparam logic [7:0] REG_SLIP_LIM     = 8'h32;
  localparam logic [7:0] REG_CLK_CFG      = 8'h33;
  localparam logic [7:0] REG_CLK_DIV0     = 8'h34;
  localparam logic [7:0] REG_CLK_DIV1     = 8'h35;
  localparam logic [7:0] REG_EE_CMD       = 8'h36;
  localparam logic [7:0] REG_EE_COUNT     = 8'h37;
  localparam int         LOS_PRI_THR_LSB  = 0;
  localparam int         LOS_SEC_THR_LSB  = 2;
  localparam int         LOS_PRI_SLEW_LSB = 4;
  localparam int         LOS_SEC_SLEW_LSB = 6;
  localparam int         CLK_LOOP_LSB     = 2;
  localparam logic [7:0] EE_MAX           = 8'h64;
endpackage

//--- design/cssi_top.sv
// Purpose: Serial config port, loss detect, lock detect, status pins
// Assumes: Bus pins and monitor inputs are asynchronous to clk
// Notes: Register map is a small flop array behind the serial slave
`timescale 1ns/10ps
`default_nettype none
module cssi_top #(
  parameter int SLIP_W = 8,
  parameter int AUX_W  = 12
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              scl,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe,
  input  wire logic              powerdownPinN,
  input  wire logic              configSourceSelectPin,
  input  wire logic              softPinMode,
  input  wire logic [1:0]        addressStrapPin,
  input  wire logic              primaryReferenceSwingLow,
  input  wire logic              secondaryReferenceSwingLow,
  input  wire logic [1:0]        primaryReferenceSlew,
  input  wire logic [1:0]        secondaryReferenceSlew,
  input  wire logic              primaryReferenceSingleEnded,
  input  wire logic              secondaryReferenceSingleEnded,
  input  wire logic [1:0]        loopSlipToggle,
  input  wire logic [AUX_W-1:0]  auxVitals,
  input  wire logic [7:0]        romData,
  input  wire logic [7:0]        eepromData,
  output logic [5:0]             loadAddr,
  output logic                   loadActive,
  output logic                   eepromProgram,
  output logic [1:0]             statusPin,
  output logic [1:0]             statusSlowEdge,
  output logic [1:0]             primaryThreshold,
  output logic [1:0]             secondaryThreshold
);
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_ACK  = 6'h04,
    S_WR   = 6'h08,
    S_RD   = 6'h10,
    S_RACK = 6'h20
  } cssi_state_t;

  localparam int         EXT_W      = 15 + AUX_W;
  localparam logic [3:0] GLITCH_CNT = 4'(cssi_pkg::GLITCH_CYC);
  localparam logic [1:0] BOOT_CNT   = 2'(cssi_pkg::BOOT_CYC);

  // Strap comparator pair to low address bits, illegal code reads low
  function automatic logic [1:0] strapLow(input logic [1:0] code);
    strapLow = (code == 2'h2) ? 2'h0 : code;
  endfunction

  // Slow-slew hit on rising and/or falling edges per mode field
  function automatic logic slewHit(input logic [1:0] slow, input logic [1:0] mode);
    slewHit = |(slow & mode);
  endfunction

  // Map address writable: inside array and not read-only
  function automatic logic isWritable(input logic [7:0] a);
    isWritable = (a < 8'(cssi_pkg::REG_DEPTH)) && (a != cssi_pkg::REG_FLAGS)
                 && (a != cssi_pkg::REG_EE_COUNT);
  endfunction

  logic [1:0]        busS1;
  logic [1:0]        busS2;
  logic [1:0]        busF;
  logic [1:0]        busP;
  logic [3:0]        fCnt [2];
  logic [EXT_W-1:0]  extS1;
  logic [EXT_W-1:0]  extS2;
  logic [1:0]        bootCnt;
  logic              booted;
  logic              srcEeprom;
  logic [1:0]        slaveLow;
  logic [7:0]        regs [cssi_pkg::REG_DEPTH];
  cssi_state_t       st;
  logic [2:0]        bitCnt;
  logic [7:0]        shReg;
  logic              byteFull;
  logic              isRead;
  logic              gotPtr;
  logic              addrPhase;
  logic [7:0]        ptr;
  logic              wrStb;
  logic [7:0]        wrAddr;
  logic [7:0]        wrData;
  logic              flagRdClr;
  logic [7:0]        rdByte;
  logic [3:0]        flags;
  logic [1:0]        slipP;
  logic [SLIP_W-1:0] slipCnt [2];
  logic [7:0]        eeCount;
  logic [7:0]        clkCnt [2];
  logic [1:0]        clkPh;
  logic              sclRise;
  logic              sclFall;
  logic              startEv;
  logic              stopEv;
  logic              pdnOk;
  logic              cfgSel;
  logic              softMode;
  logic [1:0]        strap;
  logic              priSwing;
  logic              secSwing;
  logic [1:0]        priSlew;
  logic [1:0]        secSlew;
  logic              priSe;
  logic              secSe;
  logic [1:0]        slipTog;
  logic [AUX_W-1:0]  aux;
  logic              losPri;
  logic              losSec;
  logic [1:0]        slipEv;
  logic [1:0]        lolSet;
  logic [15:0]       vitals;
  logic [3:0]        selArr [2];
  logic [7:0]        divArr [2];
  logic [7:0]        losCfg;
  logic [7:0]        clkCfg;

  ////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every pin-side input
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      busS1 <= 2'h3;
      busS2 <= 2'h3;
      extS1 <= '0;
      extS2 <= '0;
    end
    else
    begin
      busS1 <= {sdaIn, scl};
      busS2 <= busS1;
      extS1 <= {powerdownPinN, configSourceSelectPin, softPinMode, addressStrapPin,
                primaryReferenceSwingLow, secondaryReferenceSwingLow,
                primaryReferenceSlew, secondaryReferenceSlew,
                primaryReferenceSingleEnded, secondaryReferenceSingleEnded,
                loopSlipToggle, auxVitals};
      extS2 <= extS1;
    end

  // Unpack synchronised inputs
  assign {pdnOk, cfgSel, softMode, strap, priSwing, secSwing, priSlew, secSlew,
          priSe, secSe, slipTog, aux} = extS2;

  // Glitch filter: a level must hold GLITCH_CYC cycles to pass
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      busF <= 2'h3;
      busP <= 2'h3;
      fCnt <= '{4'h0, 4'h0};
    end
    else
    begin
      busP <= busF;
      for (int i = 0; i < 2; i++)
        if (busS2[i] == busF[i])
          fCnt[i] <= 4'h0;
        else if (fCnt[i] == GLITCH_CNT - 4'h1)
        begin
          busF[i] <= busS2[i];
          fCnt[i] <= 4'h0;
        end
        else
          fCnt[i] <= fCnt[i] + 4'h1;
    end

  // Bus events on filtered lines, bit 0 clock, bit 1 data
  assign sclRise = busF[0] & ~busP[0];
  assign sclFall = ~busF[0] & busP[0];
  assign startEv = busF[0] & busP[0] & busP[1] & ~busF[1];
  assign stopEv  = busF[0] & busP[0] & ~busP[1] & busF[1];

  ////////////////////////////////////////////////////////////////////
  // Boot: settle, catch straps, then copy image into the map
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      bootCnt <= 2'h0;
      booted <= 1'b0;
      srcEeprom <= 1'b0;
      slaveLow <= 2'h0;
      loadActive <= 1'b0;
      loadAddr <= 6'h00;
    end
    else if (!booted)
    begin
      if (bootCnt == BOOT_CNT)
      begin
        booted <= 1'b1;
        loadActive <= 1'b1;
        srcEeprom <= cfgSel;
        slaveLow <= softMode ? strapLow(strap) : 2'h0;
      end
      else
        bootCnt <= bootCnt + 2'h1;
    end
    else if (loadActive)
    begin
      loadAddr <= loadAddr + 6'h01;
      loadActive <= (loadAddr != 6'h3f);
    end

  // Register array: boot image first, then host writes
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < cssi_pkg::REG_DEPTH; i++)
        regs[i] <= cssi_pkg::REG_RESET;
    end
    else if (loadActive)
      regs[loadAddr] <= srcEeprom ? eepromData : romData;
    else if (wrStb && isWritable(wrAddr))
      regs[wrAddr[cssi_pkg::REG_AW-1:0]] <= wrData;

  // Read mux, read-only state comes from live flops
  always_comb
  begin
    rdByte = 8'h00;
    if (ptr == cssi_pkg::REG_FLAGS)
      rdByte = {4'h0, flags};
    else if (ptr == cssi_pkg::REG_EE_COUNT)
      rdByte = eeCount;
    else if (ptr < 8'(cssi_pkg::REG_DEPTH))
      rdByte = regs[ptr[cssi_pkg::REG_AW-1:0]];
  end

  ////////////////////////////////////////////////////////////////////
  // Serial slave: address, pointer, data bytes with ack
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      st <= S_IDLE;
      bitCnt <= 3'h0;
      shReg <= 8'h00;
      byteFull <= 1'b0;
      isRead <= 1'b0;
      gotPtr <= 1'b0;
      addrPhase <= 1'b0;
      ptr <= 8'h00;
      sdaOe <= 1'b0;
      wrStb <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 8'h00;
      flagRdClr <= 1'b0;
    end
    else
    begin
      wrStb <= 1'b0;
      flagRdClr <= 1'b0;
      if (stopEv || !pdnOk)
      begin
        st <= S_IDLE;
        sdaOe <= 1'b0;
      end
      else if (startEv)
      begin
        st <= S_ADDR;
        bitCnt <= 3'h0;
        byteFull <= 1'b0;
        gotPtr <= 1'b0;
        sdaOe <= 1'b0;
      end
      else
        unique case (st)
          S_IDLE:
            sdaOe <= 1'b0;
          S_ADDR, S_WR:
            if (sclRise)
            begin
              shReg <= {shReg[6:0], busF[1]};
              bitCnt <= bitCnt + 3'h1;
              byteFull <= (bitCnt == 3'h7);
            end
            else if (sclFall && byteFull)
            begin
              byteFull <= 1'b0;
              addrPhase <= (st == S_ADDR);
              if (st == S_ADDR)
              begin
                if (shReg[7:1] == {cssi_pkg::ADDR_HI, slaveLow} && !loadActive)
                begin
                  st <= S_ACK;
                  sdaOe <= 1'b1;
                  isRead <= shReg[0];
                end
                else
                  st <= S_IDLE;
              end
              else
              begin
                st <= S_ACK;
                sdaOe <= 1'b1;
                if (!gotPtr)
                begin
                  ptr <= shReg;
                  gotPtr <= 1'b1;
                end
                else
                begin
                  wrStb <= 1'b1;
                  wrAddr <= ptr;
                  wrData <= shReg;
                  ptr <= ptr + 8'h01;
                end
              end
            end
          S_ACK:
            if (sclFall)
            begin
              bitCnt <= 3'h0;
              if (isRead)
              begin
                st <= S_RD;
                sdaOe <= ~rdByte[7];
                shReg <= {rdByte[6:0], 1'b0};
                bitCnt <= 3'h1;
                ptr <= ptr + 8'h01;
                flagRdClr <= (ptr == cssi_pkg::REG_FLAGS);
              end
              else
              begin
                st <= S_WR;
                sdaOe <= 1'b0;
              end
            end
          S_RD:
            if (sclFall)
            begin
              if (bitCnt == 3'h0)
              begin
                st <= S_RACK;
                sdaOe <= 1'b0;
              end
              else
              begin
                sdaOe <= ~shReg[7];
                shReg <= {shReg[6:0], 1'b0};
                bitCnt <= bitCnt + 3'h1;
              end
            end
          S_RACK:
            if (sclRise)
              st <= busF[1] ? S_IDLE : S_ACK;
        endcase
    end

  // Open-drain data line only ever pulls low
  always_ff @(posedge clk or posedge rst)
    if (rst)
      sdaOut <= 1'b0;
    else
      sdaOut <= 1'b0;

  ////////////////////////////////////////////////////////////////////
  // Loss of signal: swing always, slew only for single-ended
  assign losCfg = regs[cssi_pkg::REG_LOSCFG[5:0]];
  assign losPri = priSwing | (priSe & slewHit(priSlew,
                  losCfg[cssi_pkg::LOS_PRI_SLEW_LSB +: 2]));
  assign losSec = secSwing | (secSe & slewHit(secSlew,
                  losCfg[cssi_pkg::LOS_SEC_SLEW_LSB +: 2]));
  assign primaryThreshold = losCfg[cssi_pkg::LOS_PRI_THR_LSB +: 2];
  assign secondaryThreshold = losCfg[cssi_pkg::LOS_SEC_THR_LSB +: 2];

  // Slip events from toggles, count over limit flags loss of lock
  assign slipEv = slipTog ^ slipP;
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      lolSet[i] = slipEv[i] && (slipCnt[i] >= regs[cssi_pkg::REG_SLIP_LIM[5:0]]);
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      slipP <= 2'h0;
      slipCnt <= '{'0, '0};
    end
    else
    begin
      slipP <= slipTog;
      for (int i = 0; i < 2; i++)
        if (lolSet[i])
          slipCnt[i] <= '0;
        else if (slipEv[i])
          slipCnt[i] <= slipCnt[i] + 1'b1;
    end

  // Sticky flags, clear on readback, a new event wins
  always_ff @(posedge clk or posedge rst)
    if (rst)
      flags <= 4'h0;
    else
      flags <= (flags & ~{4{flagRdClr}}) | {lolSet, losSec, losPri};

  // EEPROM rewrite counter guards the program strobe
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      eeCount <= 8'h00;
      eepromProgram <= 1'b0;
    end
    else if (wrStb && wrAddr == cssi_pkg::REG_EE_CMD && wrData[0]
             && eeCount < cssi_pkg::EE_MAX)
    begin
      eepromProgram <= 1'b1;
      eeCount <= eeCount + 8'h01;
    end
    else
      eepromProgram <= 1'b0;

  ////////////////////////////////////////////////////////////////////
  // Vitals matrix, codes 0 to 15
  assign vitals = {aux[11:4], aux[3], aux[2], flags[3], aux[1], aux[0],
                   flags[2], losSec, losPri};
  assign selArr[0] = regs[cssi_pkg::REG_STAT_SEL0[5:0]][3:0];
  assign selArr[1] = regs[cssi_pkg::REG_STAT_SEL1[5:0]][3:0];
  assign divArr[0] = regs[cssi_pkg::REG_CLK_DIV0[5:0]];
  assign divArr[1] = regs[cssi_pkg::REG_CLK_DIV1[5:0]];
  assign clkCfg = regs[cssi_pkg::REG_CLK_CFG[5:0]];
  assign statusSlowEdge = regs[cssi_pkg::REG_SLEW[5:0]][1:0];

  // Status pins: event select or divided clock with mute
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      statusPin <= 2'h0;
      clkPh <= 2'h0;
      clkCnt <= '{8'h00, 8'h00};
    end
    else
      for (int i = 0; i < 2; i++)
      begin
        if (!clkCfg[i] || clkCnt[i] >= divArr[i])
        begin
          clkCnt[i] <= 8'h00;
          clkPh[i] <= clkCfg[i] & ~clkPh[i];
        end
        else
          clkCnt[i] <= clkCnt[i] + 8'h01;
        if (!clkCfg[i])
          statusPin[i] <= vitals[selArr[i]] ^ regs[cssi_pkg::REG_STAT_POL[5:0]][i];
        else if (regs[cssi_pkg::REG_STAT_MUTE[5:0]][i]
                 && flags[2 + 32'(clkCfg[cssi_pkg::CLK_LOOP_LSB + i])])
          statusPin[i] <= regs[cssi_pkg::REG_STAT_POL[5:0]][i];
        else
          statusPin[i] <= clkPh[i] ^ regs[cssi_pkg::REG_STAT_POL[5:0]][i];
      end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  glitch_pass_a: assert property ($rose(busF[0]) |-> $past(busS2[0], 12))
    else $error("clock line passed a short pulse");
  addr_match_a: assert property ($rose(sdaOe) && addrPhase && st == S_ACK |->
    shReg[7:3] == cssi_pkg::ADDR_HI && shReg[2:1] == slaveLow)
    else $error("acked a foreign address");
  data_low_a: assert property ($rose(sdaOe) |-> !busF[0])
    else $error("data driven while clock high");
  eight_bits_a: assert property ($rose(st == S_ACK) && !addrPhase
    && !$past(st == S_RACK) |-> $past(bitCnt) == 3'h0)
    else $error("ack after wrong bit count");
  ro_write_a: assert property (wrStb && wrAddr == cssi_pkg::REG_EE_COUNT |=>
    $stable(eeCount))
    else $error("read-only register changed");
  ee_limit_a: assert property (eepromProgram |-> eeCount <= cssi_pkg::EE_MAX
    && $past(eeCount) < cssi_pkg::EE_MAX)
    else $error("eeprom rewritten past limit");
  los_flag_a: assert property (losPri |=> flags[0])
    else $error("loss event not flagged");
  slip_reset_a: assert property (lolSet[0] |=> flags[2] && slipCnt[0] == '0)
    else $error("slip limit not handled");
  mute_hold_a: assert property (clkCfg[0] && regs[cssi_pkg::REG_STAT_MUTE[5:0]][0]
    && flags[2] && !clkCfg[cssi_pkg::CLK_LOOP_LSB]
    |=> statusPin[0] == $past(regs[cssi_pkg::REG_STAT_POL[5:0]][0]))
    else $error("muted status clock moved");
  ptr_incr_a: assert property (wrStb |-> ptr == wrAddr + 8'h01)
    else $error("pointer not advanced after write");

  write_seen_c: cover property (wrStb ##[1:1000] stopEv);
  read_seen_c: cover property ((st == S_RACK) ##1 (st == S_ACK));
  lock_lost_c: cover property (lolSet[1]);
  clk_out_c: cover property (clkCfg[1] && $rose(statusPin[1]));
endmodule
`default_nettype wire

//--- test/cssi_host.sv
// Purpose: Bus master model for the serial config port
// Assumes: Open-drain data line with pull-up, wire level fed back on sda
// Notes: Quarter bit period is Q core cycles; optional spikes on data
`timescale 1ns/10ps
`default_nettype none
module cssi_host #(
  parameter int Q = 25
) (
  input  wire logic clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sdaLow
);
  logic glitch;

  // Idle bus: both lines released
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
    glitch = 1'b0;
  end

  task automatic q();
    repeat (Q) @(posedge clk);
  endtask

  // Start or repeated start, data falls while clock high
  task automatic start();
    sdaLow <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sdaLow <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask

  // Stop, data rises while clock high
  task automatic stop();
    sdaLow <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sdaLow <= 1'b0;
    q();
  endtask

  // One bit: data set in low phase, held through high phase
  task automatic bitIo(input logic b, output logic r);
    sdaLow <= ~b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    if (glitch)
    begin
      sdaLow <= b;  // 40 ns spike against the bit
      repeat (10) @(posedge clk);
      sdaLow <= ~b;
    end
    q();
    scl <= 1'b0;
    q();
  endtask

  // Byte out, MSB first, then the receiver's acknowledge
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitIo(d[i], r);
    end
    bitIo(1'b1, ack);
  endtask

  // Byte in, MSB first, then our acknowledge or final no-ack
  task automatic rdByte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitIo(1'b1, r);
      d[i] = r;
    end
    bitIo(last, r);
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Purpose: Self-checking bench for the config and status serial block
// Assumes: Strap at mid level, boot from the on-chip image
// Notes: Bus runs faster than standard rates to keep the run short
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [6:0] SLV = {cssi_pkg::ADDR_HI, 2'b01};
  localparam logic [3:0] CODE [12] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9,
                                       4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
  logic        clk, rst, scl, hostLow, sdaLine, sdaOut, sdaOe, loadActive;
  logic        eepromProgram, pSwingLow, sSwingLow, pSingle, a;
  logic [1:0]  pSlew, sSlew, slip, statusPin, statusSlowEdge, pThr, sThr;
  logic [11:0] auxVitals;
  logic [7:0]  romData, eepromData, d0, d1;
  logic [5:0]  loadAddr;
  logic [7:0]  progPulses = 8'h00;
  logic [1:0]  pinPrev = 2'h0;
  int          rise0 = 0;
  int          rise1 = 0;
  int          failCount = 0;
  int          nCompared = 0;

  // Wired-AND data line and boot memories
  assign sdaLine = !((sdaOe && !sdaOut) || hostLow);
  assign romData = (loadAddr == 6'h19) ? 8'h3c : 8'h00;
  assign eepromData = ~romData;

  // Core clock, 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Count programming pulses and status pin rising edges
  always_ff @(posedge clk)
  begin
    pinPrev <= statusPin;
    if (eepromProgram) progPulses <= progPulses + 8'h01;
    if (statusPin[0] && !pinPrev[0]) rise0 <= rise0 + 1;
    if (statusPin[1] && !pinPrev[1]) rise1 <= rise1 + 1;
  end

  cssi_host i_host (.clk, .sda(sdaLine), .scl, .sdaLow(hostLow));

  cssi_top i_dut (.clk, .rst, .scl, .sdaIn(sdaLine), .sdaOut, .sdaOe,
    .powerdownPinN(1'b1),
    .configSourceSelectPin(1'b0), .softPinMode(1'b1), .addressStrapPin(2'b01),
    .primaryReferenceSwingLow(pSwingLow), .secondaryReferenceSwingLow(sSwingLow),
    .primaryReferenceSlew(pSlew), .secondaryReferenceSlew(sSlew),
    .primaryReferenceSingleEnded(pSingle), .secondaryReferenceSingleEnded(1'b0),
    .loopSlipToggle(slip), .auxVitals, .romData, .eepromData, .loadAddr,
    .loadActive, .eepromProgram, .statusPin, .statusSlowEdge,
    .primaryThreshold(pThr), .secondaryThreshold(sThr));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    nCompared++;
    if (got !== exp)
    begin
      failCount++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Two-byte write from pointer ra
  task automatic wr(input logic [7:0] ra, input logic [7:0] x0, input logic [7:0] x1);
    logic a0, a1, a2, a3;
    i_host.start();
    i_host.wrByte({SLV, 1'b0}, a0);
    i_host.wrByte(ra, a1);
    i_host.wrByte(x0, a2);
    i_host.wrByte(x1, a3);
    i_host.stop();
    chk({4'h0, a0, a1, a2, a3}, 8'h00, "write acks");
  endtask

  // Two-byte read from pointer ra
  task automatic rd(input logic [7:0] ra, output logic [7:0] x0, output logic [7:0] x1);
    logic a0, a1, a2;
    i_host.start();
    i_host.wrByte({SLV, 1'b0}, a0);
    i_host.wrByte(ra, a1);
    i_host.start();
    i_host.wrByte({SLV, 1'b1}, a2);
    i_host.rdByte(1'b0, x0);
    i_host.rdByte(1'b1, x1);
    i_host.stop();
    chk({5'h0, a0, a1, a2}, 8'h00, "read acks");
  endtask

  task automatic slips(input int n);
    repeat (n)
    begin
      slip[0] <= ~slip[0];
      repeat (8) @(posedge clk);
    end
  endtask

  // Rising edges on each status pin over an 80-cycle window
  task automatic clocks(input int e0, input int e1, input string what);
    int s0;
    int s1;
    s0 = rise0;
    s1 = rise1;
    repeat (80) @(posedge clk);
    chk(8'(rise0 - s0), 8'(e0), what);
    chk(8'(rise1 - s1), 8'(e1), what);
  endtask

  task automatic pins(input logic [1:0] exp, input string what);
    repeat (10) @(posedge clk);
    chk({6'h0, statusPin}, {6'h0, exp}, what);
  endtask

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    failCount++;
    conclude();
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    {pSwingLow, sSwingLow, pSingle, pSlew, sSlew, slip, auxVitals} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (100) @(posedge clk);
    i_host.start();
    i_host.wrByte({SLV, 1'b0}, a); // first transaction discarded
    i_host.stop();
    rd(cssi_pkg::REG_LOSCFG, d0, d1);
    chk(d0, 8'h3c, "boot image");
    chk({4'h0, sThr, pThr}, 8'h0c, "boot thresholds");
    i_host.start();
    i_host.wrByte({SLV ^ 7'h01, 1'b0}, a);
    i_host.stop();
    chk({7'h0, a}, 8'h01, "foreign address");
    $display("test boot and address done");
    i_host.glitch = 1'b1;
    wr(cssi_pkg::REG_LOSCFG, 8'ha5, 8'h3c);
    i_host.glitch = 1'b0;
    rd(cssi_pkg::REG_LOSCFG, d0, d1);
    chk(d0, 8'ha5, "spiked write");
    chk(d1, 8'h3c, "next pointer");
    chk({4'h0, sThr, pThr}, 8'h05, "thresholds");
    wr(cssi_pkg::REG_FLAGS, 8'hff, 8'h00);
    rd(cssi_pkg::REG_FLAGS, d0, d1);
    chk(d0, 8'h00, "flags write");
    $display("test burst and spike done");
    wr(cssi_pkg::REG_STAT_SEL0, 8'h00, 8'h01);
    pSingle <= 1'b1;
    pSlew <= 2'b01;
    pins(2'b00, "rise unmonitored");
    pSlew <= 2'b10;
    pins(2'b01, "primary loss");
    pSlew <= 2'b00;
    sSwingLow <= 1'b1;
    pins(2'b10, "secondary loss");
    sSwingLow <= 1'b0;
    rd(cssi_pkg::REG_FLAGS, d0, d1);
    chk(d0, 8'h03, "loss flags");
    $display("test signal loss done");
    wr(cssi_pkg::REG_SLEW, 8'h02, 8'h02);
    chk({6'h0, statusSlowEdge}, 8'h02, "slow edges");
    wr(cssi_pkg::REG_STAT_SEL0, 8'h02, 8'h05);
    slips(2);
    pins(2'b00, "at limit");
    slips(1);
    pins(2'b01, "over limit");
    rd(cssi_pkg::REG_FLAGS, d0, d1);
    chk(d0, 8'h04, "lock flag");
    slips(2);
    pins(2'b00, "counter restarted");
    $display("test lock loss done");
    for (int k = 0; k < 6; k++)
    begin
      wr(cssi_pkg::REG_STAT_SEL0, {4'h0, CODE[2*k]}, {4'h0, CODE[2*k+1]});
      auxVitals <= 12'h001 << (2 * k);
      pins(2'b01, "even code");
      auxVitals <= 12'h002 << (2 * k);
      pins(2'b10, "odd code");
    end
    auxVitals <= '0;
    $display("test status codes done");
    wr(cssi_pkg::REG_CLK_CFG, 8'h03, 8'h03);
    clocks(10, 40, "status clocks");
    wr(cssi_pkg::REG_STAT_MUTE, 8'h01, 8'h00);
    slips(1);
    clocks(0, 40, "muted clock");
    chk({7'h0, statusPin[0]}, 8'h00, "mute level");
    $display("test status clocks done");
    wr(cssi_pkg::REG_EE_CMD, 8'h01, 8'hff);
    rd(cssi_pkg::REG_EE_COUNT, d0, d1);
    chk(d0, 8'h01, "program count");
    chk(progPulses, 8'h01, "program pulses");
    $display("test eeprom done");
    conclude();
  end
endmodule
`default_nettype wire
